/* File: peak_power_defines.svh */
`ifndef PEAK_POWER_DEFINES_SVH
`define PEAK_POWER_DEFINES_SVH

// ==========================================================
// Command code, reset value and field positions
`define CFG2_CMD 8'h31
`define CFG2_RST 16'h02b7
`define B_WIN_HI 15
`define B_WIN_LO 14
`define B_EN_OVERSHOOT 13
`define B_EN_UNDERSHOOT 12
`define B_OVL_FLAG 11
`define B_RLX_FLAG 10
`define B_PER_HI 9
`define B_PER_LO 8
`define B_MERGE 7
`define B_MON_DIR 6
`define B_FET_TRIP 5
`define B_SENSE_TRIP 4
`define B_IN_OC_EN 3
`define B_IN_OC_LVL 2
`define B_DIS_OC_EN 1
`define B_DIS_OC_LVL 0

// ==========================================================
// Overload window and cycle period, in milliseconds
`define WIN_SEL0_MS 6'h01
`define WIN_SEL1_MS 6'h02
`define WIN_SEL2_MS 6'h0a
`define WIN_SEL3_MS 6'h14
`define PER_SEL0_MS 6'h05
`define PER_SEL1_MS 6'h0a
`define PER_SEL2_MS 6'h14
`define PER_SEL3_MS 6'h28

// ==========================================================
// Timing
`define CLK_HZ 10000000
`define MS_TIME_US 1000
`define BLANK_TIME_US 100
`define MS_CYCLES ((`CLK_HZ / 1000000) * `MS_TIME_US)
`define BLANK_CYCLES ((`CLK_HZ / 1000000) * `BLANK_TIME_US)

`endif

/* File: peak_power_pkg.sv */
// ==========================================================
// Shared types
package peak_power_pkg;

  typedef enum logic [1:0] {
    PK_IDLE = 2'h0,
    PK_OVERLOAD = 2'h1,
    PK_RELAX = 2'h3
  } pk_state_e;

endpackage

/* File: pin_sense_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Cleaned pin levels from the synchroniser
interface pin_sense_if #(
  parameter int W = 5
);
  logic [W-1:0] level;

  modport drv (output level);
  modport use_side (input level);
endinterface

`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
module pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire logic [W-1:0] pin_i,
  // Clean levels
  pin_sense_if.drv sen
);

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sen.level = out_q;

endmodule

`default_nettype wire

/* File: ms_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Millisecond enable pulse, restartable
module ms_tick #(
  parameter int unsigned COUNT = 10000
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  output logic tick_o
);

  localparam int unsigned CW = $clog2(COUNT);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    cnt_d = CW'(cnt_q + 1'b1);
    tick_d = 1'b0;
    if (clr_i) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

`default_nettype wire

/* File: peak_power_ocp_config.sv */
// Operation
// [R1] Option word answers at command 31h; every field is host readable and writable; bits 11-10 read the cycle state and a write does not store them.
// [R2] Bits 15-14 pick overload window: 1, 2, 10 or 20 ms.
// [R3] Bit 13 lets an input current overshoot start peak power mode.
// [R4] Bit 12 lets a system voltage undershoot start peak power mode.
// [R5] Both trigger enables clear keeps peak power mode fully off.
// [R6] Adapter removal clears both trigger enables.
// [R7] Bit 11 shows overload cycle; writing 0 ends it.
// [R8] Bit 10 shows relax cycle; writing 0 ends it.
// [R9] Bits 9-8 pick cycle period: 5, 10, 20 or 40 ms.
// [R10] Overload window longer than period means no relax interval.
// [R11] Bit 7 set gives lower of pin and register limit, else register.
// [R12] Bit 6 picks monitor direction: discharge at 0, charge at 1.
// [R13] Bit 5 picks low-side switch trip: 210 mV or 150 mV.
// [R14] Bit 4 picks input sense trip: 280 mV or 150 mV.
// [R15] Bit 3 enables input overcurrent shutdown after 100 us blank-out.
// [R16] Bit 2 picks input overcurrent level: 125% or 200% of critical.
// [R17] Bit 1 enables battery discharge overcurrent shutdown.
// [R18] Bit 0 picks discharge overcurrent level: 125% or 200% of limit.
`timescale 1ns/1ps
`default_nettype none
`include "peak_power_defines.svh"

module peak_power_ocp_config #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES,
  parameter int LW = 7
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Host command port
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_stb_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  // Asynchronous sense pins
  input wire logic adapter_present_i,
  input wire logic input_overshoot_i,
  input wire logic sys_undershoot_i,
  input wire logic input_overcurrent_trip_i,
  input wire logic discharge_overcurrent_trip_i,
  // Current limit sources
  input wire logic [LW-1:0] limit_pin_i,
  input wire logic [LW-1:0] input_limit_register_i,
  output logic [LW-1:0] input_limit_o,
  // Analog configuration
  output logic current_monitor_dir_sel_o,
  output logic low_side_fet_trip_sel_o,
  output logic input_sense_trip_sel_o,
  output logic input_overcurrent_level_sel_o,
  output logic discharge_overcurrent_level_sel_o,
  // Status and protection
  output logic overload_cycle_flag_o,
  output logic relax_cycle_flag_o,
  output logic converter_off_o
);

  localparam int unsigned BLANK_CYC = `BLANK_CYCLES;
  localparam int unsigned BW = $clog2(BLANK_CYC + 1);
  localparam logic [BW-1:0] BLANK_END = BW'(BLANK_CYC);

  // ==========================================================
  // Window and period decode
  function automatic logic [5:0] win_ms(input logic [1:0] sel);
    case (sel)
      2'h0: win_ms = `WIN_SEL0_MS;
      2'h1: win_ms = `WIN_SEL1_MS;
      2'h2: win_ms = `WIN_SEL2_MS;
      default: win_ms = `WIN_SEL3_MS;
    endcase
  endfunction

  function automatic logic [5:0] per_ms(input logic [1:0] sel);
    case (sel)
      2'h0: per_ms = `PER_SEL0_MS;
      2'h1: per_ms = `PER_SEL1_MS;
      2'h2: per_ms = `PER_SEL2_MS;
      default: per_ms = `PER_SEL3_MS;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers and millisecond timer
  pin_sense_if #(.W(5)) sen ();

  pin_sync #(.W(5)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i({discharge_overcurrent_trip_i, input_overcurrent_trip_i,
            sys_undershoot_i, input_overshoot_i, adapter_present_i}),
    .sen(sen.drv)
  );

  logic adapter, overshoot, undershoot, in_oc, dis_oc;
  assign {dis_oc, in_oc, undershoot, overshoot, adapter} = sen.level;

  logic tick, tick_clr;

  ms_tick #(.COUNT(MS_CYCLES)) u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clr_i(tick_clr),
    .tick_o(tick)
  );

  // ==========================================================
  // State
  logic [15:0] cfg_q, cfg_d;
  peak_power_pkg::pk_state_e state_q, state_d;
  logic [5:0] ms_cnt_q, ms_cnt_d;
  logic adp_q;
  logic ovl_q, ovl_d, rlx_q, rlx_d;
  logic [BW-1:0] in_cnt_q, in_cnt_d;
  logic in_off_q, in_off_d, dis_off_q, dis_off_d;
  logic off_q, off_d;
  logic [15:0] rd_q, rd_d;
  logic [LW-1:0] lim_q, lim_d;

  logic host_wr, adp_fall, any_en, trig;
  logic [5:0] win, per, ms_next;

  assign host_wr = wr_stb_i && (cmd_code_i == `CFG2_CMD);
  assign adp_fall = adp_q && !adapter;
  assign any_en = cfg_q[`B_EN_OVERSHOOT] || cfg_q[`B_EN_UNDERSHOOT];
  assign trig = (cfg_q[`B_EN_OVERSHOOT] && overshoot) ||                  // [R3]
                (cfg_q[`B_EN_UNDERSHOOT] && undershoot);                  // [R4]
  assign win = win_ms(cfg_q[`B_WIN_HI:`B_WIN_LO]);                        // [R2]
  assign per = per_ms(cfg_q[`B_PER_HI:`B_PER_LO]);                        // [R9]
  assign ms_next = 6'(ms_cnt_q + 6'h01);
  assign tick_clr = (state_d != state_q);

  // ==========================================================
  // Next-state logic
  always_comb begin
    cfg_d = cfg_q;
    state_d = state_q;
    ms_cnt_d = tick ? ms_next : ms_cnt_q;
    in_cnt_d = '0;
    in_off_d = in_off_q;
    dis_off_d = dis_off_q;
    // Option word store; flag bits always come from the state machine
    if (host_wr) begin
      cfg_d = wr_data_i;                                                  // [R1]
      cfg_d[`B_OVL_FLAG] = 1'b0;
      cfg_d[`B_RLX_FLAG] = 1'b0;
    end
    if (adp_fall) begin
      cfg_d[`B_EN_OVERSHOOT] = 1'b0;                                      // [R6]
      cfg_d[`B_EN_UNDERSHOOT] = 1'b0;                                     // [R6]
    end
    // Peak power cycle
    case (state_q)
      peak_power_pkg::PK_IDLE: begin
        if (trig) begin
          state_d = peak_power_pkg::PK_OVERLOAD;
        end
      end
      peak_power_pkg::PK_OVERLOAD: begin
        if (host_wr && !wr_data_i[`B_OVL_FLAG]) begin
          state_d = peak_power_pkg::PK_IDLE;                              // [R7]
        end else if (tick && ms_next >= win) begin
          if (per > win) begin
            state_d = peak_power_pkg::PK_RELAX;                           // [R9]
          end else begin
            state_d = peak_power_pkg::PK_IDLE;                            // [R10]
          end
        end
      end
      peak_power_pkg::PK_RELAX: begin
        if (host_wr && !wr_data_i[`B_RLX_FLAG]) begin
          state_d = peak_power_pkg::PK_IDLE;                              // [R8]
        end else if (tick && ms_next >= 6'(per - win)) begin
          state_d = peak_power_pkg::PK_IDLE;                              // [R9]
        end
      end
      default: begin
        state_d = peak_power_pkg::PK_IDLE;
      end
    endcase
    if (!any_en) begin
      state_d = peak_power_pkg::PK_IDLE;                                  // [R5]
    end
    if (state_d != state_q) begin
      ms_cnt_d = '0;
    end
    ovl_d = (state_d == peak_power_pkg::PK_OVERLOAD);                     // [R7]
    rlx_d = (state_d == peak_power_pkg::PK_RELAX);                        // [R8]
    // Input overcurrent with blank-out
    if (!cfg_q[`B_IN_OC_EN]) begin
      in_off_d = 1'b0;
    end else if (in_oc) begin
      if (in_cnt_q == BLANK_END) begin
        in_off_d = 1'b1;                                                  // [R15]
        in_cnt_d = in_cnt_q;
      end else begin
        in_cnt_d = BW'(in_cnt_q + 1'b1);
      end
    end
    // Discharge overcurrent
    if (!cfg_q[`B_DIS_OC_EN]) begin
      dis_off_d = 1'b0;
    end else if (dis_oc) begin
      dis_off_d = 1'b1;                                                   // [R17]
    end
    off_d = in_off_d || dis_off_d;
    // Current limit source
    lim_d = input_limit_register_i;
    if (cfg_q[`B_MERGE] && (limit_pin_i < input_limit_register_i)) begin
      lim_d = limit_pin_i;                                                // [R11]
    end
    // Read path
    rd_d = '0;
    if (cmd_code_i == `CFG2_CMD) begin
      rd_d = cfg_q;                                                       // [R1]
      rd_d[`B_OVL_FLAG] = ovl_q;
      rd_d[`B_RLX_FLAG] = rlx_q;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= `CFG2_RST;
      state_q <= peak_power_pkg::PK_IDLE;
      ms_cnt_q <= '0;
      adp_q <= 1'b0;
      ovl_q <= 1'b0;
      rlx_q <= 1'b0;
      in_cnt_q <= '0;
      in_off_q <= 1'b0;
      dis_off_q <= 1'b0;
      off_q <= 1'b0;
      rd_q <= '0;
      lim_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      state_q <= state_d;
      ms_cnt_q <= ms_cnt_d;
      adp_q <= adapter;
      ovl_q <= ovl_d;
      rlx_q <= rlx_d;
      in_cnt_q <= in_cnt_d;
      in_off_q <= in_off_d;
      dis_off_q <= dis_off_d;
      off_q <= off_d;
      rd_q <= rd_d;
      lim_q <= lim_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data_o = rd_q;
  assign input_limit_o = lim_q;
  assign current_monitor_dir_sel_o = cfg_q[`B_MON_DIR];                   // [R12]
  assign low_side_fet_trip_sel_o = cfg_q[`B_FET_TRIP];                    // [R13]
  assign input_sense_trip_sel_o = cfg_q[`B_SENSE_TRIP];                   // [R14]
  assign input_overcurrent_level_sel_o = cfg_q[`B_IN_OC_LVL];             // [R16]
  assign discharge_overcurrent_level_sel_o = cfg_q[`B_DIS_OC_LVL];        // [R18]
  assign overload_cycle_flag_o = ovl_q;
  assign relax_cycle_flag_o = rlx_q;
  assign converter_off_o = off_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ovl_clear;
    ovl_q && host_wr && !wr_data_i[`B_OVL_FLAG];
  endsequence

  sequence s_rlx_clear;
    rlx_q && host_wr && !wr_data_i[`B_RLX_FLAG];
  endsequence

  a_write_stores: assert property (host_wr |=> cfg_q[7:0] == $past(wr_data_i[7:0])) // [R1]
    else $error("Option word write not stored");

  a_read_returns: assert property ((cmd_code_i == `CFG2_CMD) && !host_wr ##1 !host_wr
    |-> rd_data_o[7:0] == cfg_q[7:0]) // [R1]
    else $error("Option word read wrong");

  a_disabled_idle: assert property (!any_en |=> !ovl_q && !rlx_q) // [R5]
    else $error("Peak power active with both triggers off");

  a_adapter_clears: assert property (adp_fall |=> !any_en) // [R6]
    else $error("Trigger enables kept after adapter removal");

  a_overload_exit: assert property (s_ovl_clear |=> !ovl_q) // [R7]
    else $error("Overload cycle not ended by write of 0");

  a_relax_exit: assert property (s_rlx_clear |=> !rlx_q) // [R8]
    else $error("Relax cycle not ended by write of 0");

  a_no_relax: assert property ($fell(ovl_q) && ($past(per) <= $past(win)) |-> !rlx_q) // [R10]
    else $error("Relax entered with window not shorter than period");

  a_limit_merge: assert property (1'b1 |=> input_limit_o ==
    (($past(cfg_q[`B_MERGE]) && ($past(limit_pin_i) < $past(input_limit_register_i)))
      ? $past(limit_pin_i) : $past(input_limit_register_i))) // [R11]
    else $error("Input limit source wrong");

  a_blank_out: assert property ($rose(in_off_q) |-> $past(in_cnt_q) == BLANK_END) // [R15]
    else $error("Input overcurrent shutdown before blank-out");

  a_discharge_off: assert property (cfg_q[`B_DIS_OC_EN] && dis_oc |=> ##1 converter_off_o) // [R17]
    else $error("Discharge overcurrent did not stop converter");

endmodule

`default_nettype wire

/* File: smbus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side of the command port: one whole word per access
module smbus_host_model (
  // Clock
  input wire logic mclk_i,
  // Command port
  output logic [7:0] cmd_code_o,
  output logic wr_stb_o,
  output logic [15:0] wr_data_o
);
  initial begin
    cmd_code_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 16'h0000;
  end

  // ==========================================================
  // Write; a 0 in bits 11/10 ends the running cycle
  task automatic write_word(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk_i);
    cmd_code_o = code;
    wr_stb_o = 1'b1;
    wr_data_o = data;
    @(negedge mclk_i);
    wr_stb_o = 1'b0;
    wr_data_o = ~data;
  endtask

  // ==========================================================
  // Read; the word is valid at the return
  task automatic read_word(input logic [7:0] code);
    @(negedge mclk_i);
    cmd_code_o = code;
    @(negedge mclk_i);
  endtask
endmodule

`default_nettype wire

/* File: peak_power_ocp_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module peak_power_ocp_config_tb;
  // ==========================================================
  // Signals
  logic mclk_i;
  logic rst_n_i;
  logic [7:0] cmd;
  logic stb;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic adapter, overshoot, undershoot, in_trip, dis_trip;
  logic [6:0] lim_pin, lim_reg, lim_out, lim_exp;
  logic mon_dir, fet_sel, sense_sel, in_lvl, dis_lvl, ovl, rlx, off;
  logic [15:0] stat;
  logic [15:0] cfg;
  logic [15:0] obs;
  int n_fail = 0;
  int check_count = 0;
  int seed = 84648;
  int cycles = 0;
  typedef struct packed {logic kind; logic [15:0] exp; logic [15:0] mask;} note_s;
  note_s exp_q[$];
  note_s nt;

  assign stat = {lim_out, mon_dir, fet_sel, sense_sel, in_lvl, dis_lvl, ovl, rlx, off, 1'b0};

  smbus_host_model u_host (.mclk_i(mclk_i), .cmd_code_o(cmd), .wr_stb_o(stb), .wr_data_o(wdat));

  peak_power_ocp_config #(.MS_CYCLES(10)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd), .wr_stb_i(stb),
    .wr_data_i(wdat), .rd_data_o(rdat), .adapter_present_i(adapter),
    .input_overshoot_i(overshoot), .sys_undershoot_i(undershoot),
    .input_overcurrent_trip_i(in_trip), .discharge_overcurrent_trip_i(dis_trip),
    .limit_pin_i(lim_pin), .input_limit_register_i(lim_reg), .input_limit_o(lim_out),
    .current_monitor_dir_sel_o(mon_dir), .low_side_fet_trip_sel_o(fet_sel),
    .input_sense_trip_sel_o(sense_sel), .input_overcurrent_level_sel_o(in_lvl),
    .discharge_overcurrent_level_sel_o(dis_lvl), .overload_cycle_flag_o(ovl),
    .relax_cycle_flag_o(rlx), .converter_off_o(off));

  // ==========================================================
  // Clock, timeout, verdict
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Notes and the watcher that compares them
  task automatic note(input logic kind, input logic [15:0] exp, input logic [15:0] mask);
    exp_q.push_back('{kind, exp, mask});
  endtask

  task automatic rd_chk(input logic [15:0] exp);
    u_host.read_word(8'h31);
    note(1'b0, exp, 16'hffff);
  endtask

  initial begin
    forever begin
      @(negedge mclk_i);
      #10;
      while (exp_q.size() > 0) begin
        nt = exp_q.pop_front();
        obs = nt.kind ? stat : rdat;
        check_count++;
        if ((obs & nt.mask) !== (nt.exp & nt.mask)) begin
          n_fail++;
          $display("Error at %0t: got %h expected %h", $time, obs, nt.exp);
        end
      end
    end
  end

  // ==========================================================
  // Peak power helpers
  task automatic arm(input logic [15:0] c, input logic [1:0] trig);
    u_host.write_word(8'h31, 16'h00b5);
    u_host.write_word(8'h31, c);
    {overshoot, undershoot} = trig;
    for (int k = 0; k < 20 && ovl !== 1'b1; k++) @(negedge mclk_i);
    {overshoot, undershoot} = 2'b00;
  endtask

  task automatic peak_run(input logic [1:0] win, input logic [1:0] per, input logic [1:0] en,
                          input logic [1:0] trig, input int w, input int p);
    arm({win, en, 2'b00, per, 8'hb5}, trig);
    if ((en & trig) == 2'b00) begin
      note(1'b1, 16'h0000, 16'h000c);
    end else begin
      repeat (w - 3) @(negedge mclk_i);
      note(1'b1, 16'h0008, 16'h000c);
      repeat (5) @(negedge mclk_i);
      if (p > w) begin
        note(1'b1, 16'h0004, 16'h000c);
        repeat (p - w - 5) @(negedge mclk_i);
        note(1'b1, 16'h0004, 16'h000c);
        repeat (6) @(negedge mclk_i);
      end
      note(1'b1, 16'h0000, 16'h000c);
    end
  endtask

  task automatic flag_exit(input int dly, input logic [15:0] m);
    arm(16'h23b5, 2'b10);
    repeat (dly) @(negedge mclk_i);
    note(1'b1, m, 16'h000c);
    u_host.write_word(8'h31, 16'h23b5);
    repeat (3) @(negedge mclk_i);
    note(1'b1, 16'h0000, m);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    {adapter, overshoot, undershoot, in_trip, dis_trip} = 5'b10000;
    lim_pin = 7'h7f;
    lim_reg = 7'h7f;
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd_chk(16'h02b7);
    note(1'b1, 16'hfef0, 16'hfffe);
    for (int i = 0; i < 8; i++) begin
      cfg = 16'($random(seed)) & 16'hc3f5;
      u_host.write_word(8'h30, ~cfg);
      u_host.write_word(8'h31, cfg);
      rd_chk(cfg);
      lim_pin = 7'($random(seed));
      lim_reg = 7'($random(seed));
      lim_exp = (cfg[7] && lim_pin < lim_reg) ? lim_pin : lim_reg;
      repeat (2) @(negedge mclk_i);
      note(1'b1, {lim_exp, cfg[6:4], cfg[2], cfg[0], 4'h0}, 16'hfffe);
    end
    u_host.read_word(8'h30);
    note(1'b0, 16'h0000, 16'hffff);
    peak_run(2'b00, 2'b00, 2'b10, 2'b10, 10, 50);
    peak_run(2'b11, 2'b00, 2'b01, 2'b01, 200, 50);
    peak_run(2'b10, 2'b11, 2'b11, 2'b11, 100, 400);
    peak_run(2'b01, 2'b01, 2'b00, 2'b11, 20, 100);
    peak_run(2'b01, 2'b10, 2'b01, 2'b10, 20, 200);
    flag_exit(3, 16'h0008);
    flag_exit(20, 16'h0004);
    u_host.write_word(8'h31, 16'h32b5);
    adapter = 1'b0;
    repeat (8) @(negedge mclk_i);
    rd_chk(16'h02b5);
    adapter = 1'b1;
    u_host.write_word(8'h31, 16'h00bd);
    in_trip = 1'b1;
    repeat (500) @(negedge mclk_i);
    in_trip = 1'b0;
    repeat (10) @(negedge mclk_i);
    note(1'b1, 16'h0000, 16'h0002);
    in_trip = 1'b1;
    repeat (990) @(negedge mclk_i);
    note(1'b1, 16'h0000, 16'h0002);
    repeat (20) @(negedge mclk_i);
    note(1'b1, 16'h0002, 16'h0002);
    in_trip = 1'b0;
    u_host.write_word(8'h31, 16'h00b5);
    dis_trip = 1'b1;
    repeat (10) @(negedge mclk_i);
    note(1'b1, 16'h0000, 16'h0002);
    u_host.write_word(8'h31, 16'h00b7);
    repeat (6) @(negedge mclk_i);
    note(1'b1, 16'h0002, 16'h0002);
    dis_trip = 1'b0;
    repeat (2) @(negedge mclk_i);
    test_done();
  end
endmodule

`default_nettype wire
